// [hdl/timer16_compare_status.sv]
// 16-bit free-running timer: compare outputs, force level, status flags, captures 1 and 2.
// Assumes APB master on ref_clk; capture and external clock inputs synchronous to ref_clk.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps

module timer16_compare_status (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture1Input,
  input wire logic capture2Input,
  input wire logic extClk,
  output logic compareOutputPin1,
  output logic compareOutputPin2,
  output logic compareIrq
);
  logic [15:0] cnt_ff;
  logic [2:0] pre_ff;
  logic extPrev_ff;
  logic [15:0] cmp1_ff, cmp2_ff, cap1_ff, cap2_ff;
  logic [1:0] inhibit_ff;
  logic [4:0] flags_ff;
  logic freeze_ff;
  logic [timer16_pkg::BIT_LAST:0] ctrl_ff;
  logic [4:0] armed_ff;
  logic cap1Prev_ff, cap2Prev_ff;
  logic [1:0] pinHold_ff;
  logic [1:0] matchPrev_ff;
  logic tick, acc, wr, rd, fastMode, pwmMode, forceOk;
  logic cap1Evt, cap2Evt, ovfEvt, m1, m2, hit1, hit2;
  logic [2:0] preLast;
  logic [15:0] off;
  logic [31:0] nxt_prdata;

  function automatic logic cmpHit(input logic [15:0] c, input logic [15:0] v,
                                  input logic [15:0] o);
    cmpHit = (c == v + o);
  endfunction

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign fastMode = (ctrl_ff[timer16_pkg::BIT_CLK1:timer16_pkg::BIT_CLK0] ==
                     timer16_pkg::CLK_DIV2);
  assign pwmMode = ctrl_ff[timer16_pkg::BIT_PWM];
  assign forceOk = !ctrl_ff[timer16_pkg::BIT_OPM] && !pwmMode;
  // Match offset: slow clocks see the flag one count late
  assign off = fastMode ? 16'h0000 : timer16_pkg::CNT_ONE;

  always_comb begin
    case (timer16_pkg::clk_mode_e'(ctrl_ff[timer16_pkg::BIT_CLK1:timer16_pkg::BIT_CLK0]))
      timer16_pkg::CLK_DIV2: preLast = timer16_pkg::DIV2_LAST;
      timer16_pkg::CLK_DIV4: preLast = timer16_pkg::DIV4_LAST;
      default: preLast = timer16_pkg::DIV8_LAST;
    endcase
  end

  // Prescaler frozen with the counter
  always_comb begin
    if (freeze_ff) begin
      tick = 1'b0;
    end else if (ctrl_ff[timer16_pkg::BIT_CLK1:timer16_pkg::BIT_CLK0] ==
                 timer16_pkg::CLK_EXT) begin
      tick = extClk && !extPrev_ff;
    end else begin
      tick = (pre_ff == preLast);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pre_ff <= 3'h0;
      extPrev_ff <= 1'b0;
    end else begin
      extPrev_ff <= extClk;
      if (!freeze_ff) begin
        pre_ff <= tick ? 3'h0 : pre_ff + 3'h1;
      end
    end
  end

  assign ovfEvt = tick && (cnt_ff == timer16_pkg::CNT_MAX);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= timer16_pkg::CNT_RST;
    end else if (wr && (paddr == timer16_pkg::ADDR_CNT_LO)) begin
      cnt_ff <= timer16_pkg::CNT_RST;
    end else if (tick) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  // Edge-detected captures work alongside compares
  assign cap1Evt = capture1Input && !cap1Prev_ff;
  assign cap2Evt = capture2Input && !cap2Prev_ff;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cap1Prev_ff <= 1'b0;
      cap2Prev_ff <= 1'b0;
      cap1_ff <= 16'h0000;
      cap2_ff <= 16'h0000;
    end else begin
      cap1Prev_ff <= capture1Input;
      cap2Prev_ff <= capture2Input;
      if (cap1Evt) begin
        cap1_ff <= cnt_ff;
      end
      if (cap2Evt) begin
        cap2_ff <= cnt_ff;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cmp1_ff <= {timer16_pkg::CMP1_HI_RST, timer16_pkg::CMP_LO_RST};
      cmp2_ff <= {timer16_pkg::CMP2_HI_RST, timer16_pkg::CMP_LO_RST};
      inhibit_ff <= 2'b00;
    end else if (wr) begin
      case (paddr)
        timer16_pkg::ADDR_CMP1_HI: begin
          cmp1_ff[15:8] <= pwdata[7:0];
          inhibit_ff[0] <= 1'b1;
        end
        timer16_pkg::ADDR_CMP1_LO: begin
          cmp1_ff[7:0] <= pwdata[7:0];
          inhibit_ff[0] <= 1'b0;
        end
        timer16_pkg::ADDR_CMP2_HI: begin
          cmp2_ff[15:8] <= pwdata[7:0];
          inhibit_ff[1] <= 1'b1;
        end
        timer16_pkg::ADDR_CMP2_LO: begin
          cmp2_ff[7:0] <= pwdata[7:0];
          inhibit_ff[1] <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // Level match, qualified once per count to avoid repeated flags
  assign m1 = !inhibit_ff[0] && cmpHit(cnt_ff, cmp1_ff, off);
  assign m2 = !inhibit_ff[1] && cmpHit(cnt_ff, cmp2_ff, off);
  assign hit1 = m1 && !matchPrev_ff[0];
  assign hit2 = m2 && !matchPrev_ff[1];
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      matchPrev_ff <= 2'b00;
    end else begin
      matchPrev_ff <= {m2, m1};
    end
  end

  // Clear arming: status read arms all set flags; a low-byte access clears
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      armed_ff <= 5'h00;
    end else if (rd && (paddr == timer16_pkg::ADDR_FLAGS)) begin
      armed_ff <= flags_ff;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flags_ff <= 5'h00;
    end else begin
      if (acc && armed_ff[4] && paddr == timer16_pkg::ADDR_CAP1_LO) flags_ff[4] <= 1'b0;
      if (acc && armed_ff[3] && paddr == timer16_pkg::ADDR_CMP1_LO) flags_ff[3] <= 1'b0;
      // Only the main counter low byte clears overflow
      if (acc && armed_ff[2] && paddr == timer16_pkg::ADDR_CNT_LO) flags_ff[2] <= 1'b0;
      if (acc && armed_ff[1] && paddr == timer16_pkg::ADDR_CAP2_LO) flags_ff[1] <= 1'b0;
      if (acc && armed_ff[0] && paddr == timer16_pkg::ADDR_CMP2_LO) flags_ff[0] <= 1'b0;
      if (cap1Evt || (pwmMode && hit2)) flags_ff[4] <= 1'b1;
      if (hit1) flags_ff[3] <= 1'b1;
      if (ovfEvt) flags_ff[2] <= 1'b1;
      if (cap2Evt) flags_ff[1] <= 1'b1;
      if (hit2) flags_ff[0] <= 1'b1;
    end
  end

  // Flag bits 7:3 and reserved bits 1:0 ignore writes; only freeze writable
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      freeze_ff <= 1'b0;
      ctrl_ff <= '0;
    end else begin
      if (wr && paddr == timer16_pkg::ADDR_FLAGS) begin
        freeze_ff <= pwdata[timer16_pkg::BIT_FREEZE];
      end
      if (wr && paddr == timer16_pkg::ADDR_CTRL) begin
        ctrl_ff <= pwdata[timer16_pkg::BIT_LAST:0];
      end else begin
        // Force bits are strobes and self-clear
        ctrl_ff[timer16_pkg::BIT_FORCE1] <= 1'b0;
        ctrl_ff[timer16_pkg::BIT_FORCE2] <= 1'b0;
      end
    end
  end

  // Pins: match, or force outside one-pulse and PWM modes, copies level when enabled; freeze forces low
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pinHold_ff <= 2'b00;
    end else begin
      if (ctrl_ff[timer16_pkg::BIT_OE1] && (hit1 ||
          (forceOk && ctrl_ff[timer16_pkg::BIT_FORCE1]))) begin
        pinHold_ff[0] <= ctrl_ff[timer16_pkg::BIT_LVL1];
      end
      if (ctrl_ff[timer16_pkg::BIT_OE2] && (hit2 ||
          (forceOk && ctrl_ff[timer16_pkg::BIT_FORCE2]))) begin
        pinHold_ff[1] <= ctrl_ff[timer16_pkg::BIT_LVL2];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      compareOutputPin1 <= 1'b0;
      compareOutputPin2 <= 1'b0;
      compareIrq <= 1'b0;
    end else begin
      compareOutputPin1 <= pinHold_ff[0] && !freeze_ff;
      compareOutputPin2 <= pinHold_ff[1] && !freeze_ff;
      compareIrq <= ctrl_ff[timer16_pkg::BIT_CIE] && (flags_ff[3] || flags_ff[0]);
    end
  end

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      timer16_pkg::ADDR_FLAGS: nxt_prdata[7:0] = {flags_ff, freeze_ff, 2'b00};
      timer16_pkg::ADDR_CAP1_HI: nxt_prdata[7:0] = cap1_ff[15:8];
      timer16_pkg::ADDR_CAP1_LO: nxt_prdata[7:0] = cap1_ff[7:0];
      timer16_pkg::ADDR_CMP1_HI: nxt_prdata[7:0] = cmp1_ff[15:8];
      timer16_pkg::ADDR_CMP1_LO: nxt_prdata[7:0] = cmp1_ff[7:0];
      timer16_pkg::ADDR_CMP2_HI: nxt_prdata[7:0] = cmp2_ff[15:8];
      timer16_pkg::ADDR_CMP2_LO: nxt_prdata[7:0] = cmp2_ff[7:0];
      timer16_pkg::ADDR_CNT_HI, timer16_pkg::ADDR_ALT_HI: nxt_prdata[7:0] = cnt_ff[15:8];
      timer16_pkg::ADDR_CNT_LO, timer16_pkg::ADDR_ALT_LO: nxt_prdata[7:0] = cnt_ff[7:0];
      timer16_pkg::ADDR_CAP2_HI: nxt_prdata[7:0] = cap2_ff[15:8];
      timer16_pkg::ADDR_CAP2_LO: nxt_prdata[7:0] = cap2_ff[7:0];
      timer16_pkg::ADDR_CTRL: nxt_prdata[timer16_pkg::BIT_LAST:0] = ctrl_ff;
      default: nxt_prdata = 32'h0000_0000;
    endcase
  end

  // Zero wait states: ready in the setup cycle's following access phase
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= nxt_prdata;
      pready <= psel && !penable;
      pslverr <= 1'b0;
    end
  end

  a_pin_freeze_low: assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(freeze_ff) |-> !compareOutputPin1 && !compareOutputPin2)
    else $error("Pin active while frozen");
  a_force_no_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!hit1 && !flags_ff[3]) |=> !flags_ff[3])
    else $error("Compare 1 flag set without match");
  a_inhibit_blocks: assert property (@(posedge ref_clk) disable iff (!resetn)
    inhibit_ff[0] |-> !hit1)
    else $error("Match while high byte pending");
  a_ovf_sets: assert property (@(posedge ref_clk) disable iff (!resetn)
    ovfEvt |=> flags_ff[2] && cnt_ff == 16'h0000)
    else $error("Overflow flag missed");
  a_cap1_load: assert property (@(posedge ref_clk) disable iff (!resetn)
    cap1Evt |=> flags_ff[4] && cap1_ff == $past(cnt_ff))
    else $error("Capture 1 not loaded");
  a_cap2_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
    cap2Evt |=> flags_ff[1])
    else $error("Capture 2 flag missed");
  a_alt_keep_ovf: assert property (@(posedge ref_clk) disable iff (!resetn)
    (acc && paddr == timer16_pkg::ADDR_ALT_LO && flags_ff[2]) |=> flags_ff[2])
    else $error("Alternate access cleared overflow");
  a_match_pin: assert property (@(posedge ref_clk) disable iff (!resetn)
    (hit1 && ctrl_ff[timer16_pkg::BIT_OE1] && !freeze_ff) ##1 !freeze_ff
      |=> compareOutputPin1 == $past(ctrl_ff[timer16_pkg::BIT_LVL1], 2))
    else $error("Match level not driven");
  a_fast_equal: assert property (@(posedge ref_clk) disable iff (!resetn)
    (fastMode && hit1) |-> cnt_ff == cmp1_ff)
    else $error("Fast-mode match at wrong count");
endmodule // timer16_compare_status

// [hdl/timer16_pkg.sv]
// Register map, field positions, reset values and clock modes of the 16-bit timer.
// Assumes an APB master with 32-bit data; each 8-bit register sits in the low byte of a word.
package timer16_pkg;
  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_CAP1_HI = 8'h04;
  localparam logic [7:0] ADDR_CAP1_LO = 8'h08;
  localparam logic [7:0] ADDR_CMP1_HI = 8'h0c;
  localparam logic [7:0] ADDR_CMP1_LO = 8'h10;
  localparam logic [7:0] ADDR_CMP2_HI = 8'h14;
  localparam logic [7:0] ADDR_CMP2_LO = 8'h18;
  localparam logic [7:0] ADDR_CNT_HI = 8'h1c;
  localparam logic [7:0] ADDR_CNT_LO = 8'h20;
  localparam logic [7:0] ADDR_ALT_HI = 8'h24;
  localparam logic [7:0] ADDR_ALT_LO = 8'h28;
  localparam logic [7:0] ADDR_CAP2_HI = 8'h2c;
  localparam logic [7:0] ADDR_CAP2_LO = 8'h30;
  localparam logic [7:0] ADDR_CTRL = 8'h34;
  localparam int BIT_CAP1 = 7;
  localparam int BIT_CMP1 = 6;
  localparam int BIT_OVF = 5;
  localparam int BIT_CAP2 = 4;
  localparam int BIT_CMP2 = 3;
  localparam int BIT_FREEZE = 2;
  // Control register (CTRL) fields
  localparam int BIT_OE1 = 0;
  localparam int BIT_OE2 = 1;
  localparam int BIT_LVL1 = 2;
  localparam int BIT_LVL2 = 3;
  localparam int BIT_FORCE1 = 4;
  localparam int BIT_FORCE2 = 5;
  localparam int BIT_CIE = 6;
  localparam int BIT_OPM = 7;
  localparam int BIT_PWM = 8;
  localparam int BIT_CLK0 = 9;
  localparam int BIT_CLK1 = 10;
  localparam int BIT_LAST = 10;
  localparam logic [7:0] CMP1_HI_RST = 8'h80;
  localparam logic [7:0] CMP_LO_RST = 8'h00;
  localparam logic [7:0] CMP2_HI_RST = 8'hff;
  localparam logic [15:0] CNT_RST = 16'hfffc;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [2:0] DIV2_LAST = 3'h1;
  localparam logic [2:0] DIV4_LAST = 3'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;
  typedef enum logic [1:0] {
    CLK_DIV2 = 2'b00,
    CLK_DIV4 = 2'b01,
    CLK_DIV8 = 2'b10,
    CLK_EXT = 2'b11
  } clk_mode_e;
endpackage

// [tb/timer16_pin_model.sv]
// Far-side pins: drives capture edges, keeps the external clock still, counts pin rises.
// Assumes ref_clk from the bench; all edges launched just after a rising clock edge.
`timescale 1ns/1ps
module timer16_pin_model (
  input wire logic ref_clk,
  input wire logic compareOutputPin1,
  input wire logic compareOutputPin2,
  output logic capture1Input,
  output logic capture2Input,
  output logic extClk,
  output logic [7:0] rise1,
  output logic [7:0] rise2
);
  logic prev1 = 1'b0;
  logic prev2 = 1'b0;
  initial begin
    capture1Input = 1'b0;
    capture2Input = 1'b0;
    extClk = 1'b0;
    rise1 = 8'h00;
    rise2 = 8'h00;
  end
  always @(posedge ref_clk) begin
    prev1 <= compareOutputPin1;
    prev2 <= compareOutputPin2;
    if (compareOutputPin1 && !prev1) rise1 <= rise1 + 8'h01;
    if (compareOutputPin2 && !prev2) rise2 <= rise2 + 8'h01;
  end
  // Held three cycles so the edge detector cannot miss it
  task automatic pulse(input int which);
    @(posedge ref_clk);
    if (which == 1) capture1Input <= 1'b1;
    else capture2Input <= 1'b1;
    repeat (3) @(posedge ref_clk);
    capture1Input <= 1'b0;
    capture2Input <= 1'b0;
  endtask
endmodule // timer16_pin_model

// [tb/timer16_compare_status_tb_top.sv]
// Bench for the timer compare and status block, APB tasks and directed tests.
// Assumes the pin model beside the design; no stimulus is random.
`timescale 1ns/1ps
module timer16_compare_status_tb_top;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cap1;
  logic cap2;
  logic extClk;
  logic pin1;
  logic pin2;
  logic compareIrq;
  logic [7:0] rise1;
  logic [7:0] rise2;
  logic [31:0] rv;
  logic [7:0] ch;
  logic [7:0] cl;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  always #4 ref_clk = ~ref_clk;
  timer16_compare_status uut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture1Input(cap1), .capture2Input(cap2),
    .extClk(extClk), .compareOutputPin1(pin1), .compareOutputPin2(pin2),
    .compareIrq(compareIrq));
  timer16_pin_model pm (.ref_clk(ref_clk), .compareOutputPin1(pin1),
    .compareOutputPin2(pin2), .capture1Input(cap1), .capture2Input(cap2),
    .extClk(extClk), .rise1(rise1), .rise2(rise2));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Hold the request until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge ref_clk);
    end
    rv = prdata;
    chk({7'h00, pslverr}, 8'h00);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0000_0000);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(timer16_pkg::ADDR_CMP1_HI);
    chk(rv[7:0], 8'h80);
    rd(timer16_pkg::ADDR_CMP1_LO);
    chk(rv[7:0], 8'h00);
    wr(8'h3c, 32'h0000_00ff);
    rd(8'h3c);
    chk(rv[7:0], 8'h00);
    done("reset");
    rd(timer16_pkg::ADDR_FLAGS);
    chk(rv[7:0] & 8'h20, 8'h20);
    rd(timer16_pkg::ADDR_ALT_LO);
    rd(timer16_pkg::ADDR_FLAGS);
    chk(rv[7:0] & 8'h20, 8'h20);
    rd(timer16_pkg::ADDR_CNT_LO);
    rd(timer16_pkg::ADDR_FLAGS);
    chk(rv[7:0], 8'h00);
    done("overflow");
    wr(timer16_pkg::ADDR_CTRL, 32'h0000_0005);
    wr(timer16_pkg::ADDR_CMP1_HI, 32'h0000_0000);
    wr(timer16_pkg::ADDR_CNT_LO, 32'h0000_0000);
    repeat (40) @(posedge ref_clk);
    chk({7'h00, pin1}, 8'h00);
    rd(timer16_pkg::ADDR_FLAGS);
    chk(rv[7:0] & 8'h40, 8'h00);
    wr(timer16_pkg::ADDR_CMP1_LO, 32'h0000_0010);
    wr(timer16_pkg::ADDR_CNT_LO, 32'h0000_0000);
    for (n = 0; n < 100 && pin1 !== 1'b1; n++) @(posedge ref_clk);
    chk({7'h00, pin1}, 8'h01);
    chk({7'h00, compareIrq}, 8'h00);
    rd(timer16_pkg::ADDR_FLAGS);
    chk(rv[7:0] & 8'h40, 8'h40);
    rd(timer16_pkg::ADDR_CMP1_LO);
    chk(rv[7:0], 8'h10);
    done("match");
    wr(timer16_pkg::ADDR_CTRL, 32'h0000_0011);
    repeat (2) @(posedge ref_clk);
    chk({7'h00, pin1}, 8'h00);
    rd(timer16_pkg::ADDR_FLAGS);
    chk(rv[7:0] & 8'h40, 8'h00);
    done("force");
    // Output disabled: only the flag and interrupt may react
    wr(timer16_pkg::ADDR_CTRL, 32'h0000_0044);
    wr(timer16_pkg::ADDR_CNT_LO, 32'h0000_0000);
    for (n = 0; n < 100 && compareIrq !== 1'b1; n++) @(posedge ref_clk);
    chk({7'h00, compareIrq}, 8'h01);
    chk({7'h00, pin1}, 8'h00);
    chk(rise1, 8'h01);
    chk(rise2, 8'h00);
    done("irq");
    // One-pulse mode: force strobe must not move the pin
    wr(timer16_pkg::ADDR_CTRL, 32'h0000_0095);
    repeat (3) @(posedge ref_clk);
    chk({7'h00, pin1}, 8'h00);
    done("opm force");
    // Divide by four: match lands one count past the compare value
    wr(timer16_pkg::ADDR_CTRL, 32'h0000_0205);
    wr(timer16_pkg::ADDR_CNT_LO, 32'h0000_0000);
    for (n = 0; n < 200 && pin1 !== 1'b1; n++) @(posedge ref_clk);
    rd(timer16_pkg::ADDR_CNT_LO);
    chk(rv[7:0], 8'h11);
    chk(rise1, 8'h02);
    done("div4");
    wr(timer16_pkg::ADDR_FLAGS, 32'h0000_00fc);
    rd(timer16_pkg::ADDR_FLAGS);
    chk(rv[7:0] & 8'h9f, 8'h04);
    rd(timer16_pkg::ADDR_CNT_HI);
    ch = rv[7:0];
    rd(timer16_pkg::ADDR_CNT_LO);
    cl = rv[7:0];
    repeat (10) @(posedge ref_clk);
    rd(timer16_pkg::ADDR_CNT_LO);
    chk(rv[7:0], cl);
    chk({7'h00, pin1}, 8'h00);
    pm.pulse(1);
    repeat (5) @(posedge ref_clk);
    rd(timer16_pkg::ADDR_FLAGS);
    chk(rv[7:0] & 8'h80, 8'h80);
    pm.pulse(2);
    repeat (5) @(posedge ref_clk);
    rd(timer16_pkg::ADDR_FLAGS);
    chk(rv[7:0] & 8'h90, 8'h90);
    rd(timer16_pkg::ADDR_CAP1_LO);
    chk(rv[7:0], cl);
    rd(timer16_pkg::ADDR_CAP1_HI);
    chk(rv[7:0], ch);
    rd(timer16_pkg::ADDR_FLAGS);
    chk(rv[7:0] & 8'h90, 8'h10);
    wr(timer16_pkg::ADDR_FLAGS, 32'h0000_0000);
    done("freeze capture");
    tally_and_finish();
  end
endmodule // timer16_compare_status_tb_top
